// [src/hcwd_pkg.sv]
// Constants shared by the host communication watchdog
package hcwd_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 10_000_000;  // sys_clk rate
  localparam int unsigned MS_PER_S         = 1000;
  // Cycles in one millisecond tick of the watchdog time base
  localparam int unsigned TICK_CYC         = CLK_HZ / MS_PER_S;

  // ----------------------------------------------------------------
  // Bus release timeout and stretch limits, in ms
  // ----------------------------------------------------------------
  localparam int unsigned BUS_TMO_MIN_MS   = 25;
  localparam int unsigned BUS_TMO_MAX_MS   = 35;
  localparam int unsigned SLV_STRETCH_MS   = 25;
  localparam int unsigned MST_STRETCH_MS   = 10;
  // Least times round up to whole cycles
  localparam int unsigned BUS_TMO_CYC      = (BUS_TMO_MIN_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
  localparam int unsigned BUS_TMO_MAX_CYC  = (BUS_TMO_MAX_MS * CLK_HZ) / MS_PER_S;
  // Own stretch is released one ms early so the slave limit is never met
  localparam int unsigned SLV_STRETCH_CYC  = ((SLV_STRETCH_MS - 1) * CLK_HZ) / MS_PER_S;

  // ----------------------------------------------------------------
  // Watchdog reset deglitch and periods
  // ----------------------------------------------------------------
  localparam int unsigned WD_DEGLITCH_MS   = 10;
  localparam int unsigned WD_DEGLITCH_CYC  = (WD_DEGLITCH_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
  localparam int unsigned SCL_FILT_CYC     = 2;     // Small spike filter on the clock pin
  localparam int unsigned WD_PER_A_S       = 5;
  localparam int unsigned WD_PER_B_S       = 88;
  localparam int unsigned WD_PER_C_S       = 175;
  localparam int unsigned WD_PER_A_MS      = WD_PER_A_S * MS_PER_S;
  localparam int unsigned WD_PER_B_MS      = WD_PER_B_S * MS_PER_S;
  localparam int unsigned WD_PER_C_MS      = WD_PER_C_S * MS_PER_S;

  // ----------------------------------------------------------------
  // Period select field of the charge option register, bits 14:13
  // ----------------------------------------------------------------
  localparam int unsigned WD_SEL_LSB       = 13;
  localparam int unsigned WD_SEL_MSB       = 14;
  localparam logic [1:0]  WD_SEL_OFF       = 2'h0;
  localparam logic [1:0]  WD_SEL_A         = 2'h1;
  localparam logic [1:0]  WD_SEL_B         = 2'h2;
  localparam logic [1:0]  WD_SEL_C         = 2'h3;
  localparam logic [1:0]  WD_SEL_RST       = 2'h3;  // Value after reset

endpackage : hcwd_pkg

// [src/hcwd_filter.sv]
// Two-stage synchroniser with a stability filter for one pin
module hcwd_filter #(
  parameter int unsigned FILT_CYC = 2,            // Cycles a new level must hold
  parameter int unsigned CW       = 20            // Filter counter width
) (
  input  wire logic sys_clk,                      // System clock
  input  wire logic rst_b,                        // Synchronous reset, active low
  input  wire logic pin,                          // Asynchronous pin level
  input  wire logic rst_val,                      // Level assumed after reset
  output logic      level_q,                      // Filtered level
  output logic      rise_q                        // One-cycle pulse on accepted rise
);

  logic          meta_q, meta_d;
  logic          sync_q, sync_d;
  logic [CW-1:0] cnt_q,  cnt_d;
  logic          level_d;
  logic          rise_d;
  logic          rval_q;

  // ----------------------------------------------------------------
  // Next state: a level is taken only after it held FILT_CYC cycles
  // ----------------------------------------------------------------
  always_comb begin
    meta_d  = pin;
    sync_d  = meta_q;
    cnt_d   = '0;
    level_d = level_q;
    rise_d  = 1'b0;
    if (sync_q != level_q) begin
      cnt_d = cnt_q + 1'b1;
      if (cnt_q >= CW'(FILT_CYC - 1)) begin
        level_d = sync_q;
        rise_d  = sync_q;
        cnt_d   = '0;
      end
    end
  end

  // Registers; reset level is loaded one cycle after release from rst_val
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      cnt_q   <= '0;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
      rval_q  <= 1'b0;
    end else begin
      meta_q  <= meta_d;
      sync_q  <= sync_d;
      rval_q  <= 1'b1;
      cnt_q   <= rval_q ? cnt_d : '0;
      level_q <= rval_q ? level_d : rst_val;
      rise_q  <= rval_q ? rise_d : 1'b0;
    end
  end

endmodule : hcwd_filter

// [src/hcwd_top.sv]
// Host communication watchdog: bus release timeout and host watchdog
// Overview of operation
// - Clock low past 25 ms times transfer out
// - Reset serial interface before 35 ms elapse
// - Stretch budget: master 10 ms, slave 25 ms
// - Watchdog reset acts only after 10 ms
// - Period select 5, 88, 175 s; default 175
// - Expired watchdog stops charging
module hcwd_top #(
  parameter int unsigned TICK_CYC    = hcwd_pkg::TICK_CYC,        // Cycles per ms tick
  parameter int unsigned BUS_TMO_CYC = hcwd_pkg::BUS_TMO_CYC,     // Clock low timeout
  parameter int unsigned STRETCH_CYC = hcwd_pkg::SLV_STRETCH_CYC, // Own stretch budget
  parameter int unsigned DEGL_CYC    = hcwd_pkg::WD_DEGLITCH_CYC, // Watchdog reset deglitch
  parameter int unsigned PER_A_MS    = hcwd_pkg::WD_PER_A_MS,     // Period, select 01
  parameter int unsigned PER_B_MS    = hcwd_pkg::WD_PER_B_MS,     // Period, select 10
  parameter int unsigned PER_C_MS    = hcwd_pkg::WD_PER_C_MS,     // Period, select 11
  parameter int unsigned CW          = 20,                        // Cycle counter width
  parameter int unsigned MW          = 18                         // Ms counter width
) (
  input  wire logic       sys_clk,        // System clock, 10 MHz
  input  wire logic       rst_b,          // Synchronous reset, active low
  input  wire logic       scl_pin,        // Bus clock pin level
  input  wire logic       wd_rst_pin,     // Watchdog reset pin, active high
  input  wire logic       host_wr,        // Pulse: host write accepted
  input  wire logic       opt_wr,         // Pulse: charge option register written
  input  wire logic [1:0] opt_wd_sel,     // Written value of bits 14:13
  input  wire logic       xfer_active,    // Level: a transfer is in progress
  input  wire logic       dev_scl_hold,   // Level: own logic stretches the clock
  input  wire logic       charge_req,     // Level: charging otherwise allowed
  output logic            bus_reset_q,    // Pulse: return serial interface to idle
  output logic            scl_release_q,  // Level: forbid further own stretching
  output logic [1:0]      wd_sel_q,       // Active period select
  output logic            wd_expired_q,   // Level: watchdog has expired
  output logic            charge_en_q     // Level: charging permitted
);

  // ----------------------------------------------------------------
  // Pin synchronisers and filters
  // ----------------------------------------------------------------
  logic scl_lvl;
  logic wdr_rise;

  // Short spike filter on the bus clock so noise does not restart timing
  hcwd_filter #(.FILT_CYC(hcwd_pkg::SCL_FILT_CYC), .CW(CW)) u_scl_filt (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .pin     (scl_pin),
    .rst_val (1'b1),
    .level_q (scl_lvl),
    .rise_q  ()
  );

  // Watchdog reset must hold high for the full deglitch time
  hcwd_filter #(.FILT_CYC(DEGL_CYC), .CW(CW)) u_wdr_filt (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .pin     (wd_rst_pin),
    .rst_val (1'b0),
    .level_q (),
    .rise_q  (wdr_rise)
  );

  // Map a period select code to its nominal period in ms
  function automatic logic [MW-1:0] sel_period(input logic [1:0] sel);
    logic [MW-1:0] p;
    p = '0;
    case (sel)
      hcwd_pkg::WD_SEL_A: p = MW'(PER_A_MS);
      hcwd_pkg::WD_SEL_B: p = MW'(PER_B_MS);
      hcwd_pkg::WD_SEL_C: p = MW'(PER_C_MS);
      default:            p = '0;
    endcase
    return p;
  endfunction : sel_period

  // ----------------------------------------------------------------
  // Bus release timeout and stretch budget
  // ----------------------------------------------------------------
  logic [CW-1:0] low_cnt_q, low_cnt_d;
  logic [CW-1:0] str_cnt_q, str_cnt_d;
  logic          tmo_done_q, tmo_done_d;
  logic          bus_reset_d;
  logic          scl_release_d;

  // One reset pulse per clock-low episode; stretch budget per transfer
  always_comb begin
    low_cnt_d     = '0;
    tmo_done_d    = 1'b0;
    bus_reset_d   = 1'b0;
    str_cnt_d     = '0;
    scl_release_d = 1'b0;
    if (!scl_lvl) begin
      tmo_done_d = tmo_done_q;
      low_cnt_d  = tmo_done_q ? low_cnt_q : low_cnt_q + 1'b1;
      if (!tmo_done_q && low_cnt_q >= CW'(BUS_TMO_CYC)) begin
        bus_reset_d = 1'b1;
        tmo_done_d  = 1'b1;
      end
    end
    if (xfer_active && !bus_reset_q) begin
      str_cnt_d     = (dev_scl_hold && !scl_release_q) ? str_cnt_q + 1'b1 : str_cnt_q;
      scl_release_d = scl_release_q || (str_cnt_q >= CW'(STRETCH_CYC));
    end
  end

  // Bus timing registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      low_cnt_q     <= '0;
      tmo_done_q    <= 1'b0;
      bus_reset_q   <= 1'b0;
      str_cnt_q     <= '0;
      scl_release_q <= 1'b0;
    end else begin
      low_cnt_q     <= low_cnt_d;
      tmo_done_q    <= tmo_done_d;
      bus_reset_q   <= bus_reset_d;
      str_cnt_q     <= str_cnt_d;
      scl_release_q <= scl_release_d;
    end
  end

  // ----------------------------------------------------------------
  // Host watchdog
  // ----------------------------------------------------------------
  logic [CW-1:0] tick_cnt_q, tick_cnt_d;
  logic          tick;
  logic [MW-1:0] wd_cnt_q, wd_cnt_d;
  logic [1:0]    wd_sel_d;
  logic          wd_expired_d;
  logic          charge_en_d;
  logic          service;
  logic          wd_on;

  assign tick    = (tick_cnt_q == CW'(TICK_CYC - 1));
  assign service = host_wr | opt_wr | wdr_rise;
  assign wd_on   = (wd_sel_q != hcwd_pkg::WD_SEL_OFF);

  // Ms time base, count restart on service, expiry sets sticky flag
  always_comb begin
    tick_cnt_d   = tick ? '0 : tick_cnt_q + 1'b1;
    wd_sel_d     = opt_wr ? opt_wd_sel : wd_sel_q;
    wd_cnt_d     = wd_cnt_q;
    wd_expired_d = wd_expired_q;
    if (service) begin
      wd_cnt_d     = '0;
      wd_expired_d = 1'b0;
    end else if (wd_on && tick && !wd_expired_q) begin
      wd_cnt_d = wd_cnt_q + 1'b1;
    end
    // Expiry wins over a same-cycle service so a late service does not mask the expiry
    if (wd_on && !wd_expired_q && wd_cnt_q >= sel_period(wd_sel_q)) begin
      wd_expired_d = 1'b1;
    end
    if (!wd_on) begin
      wd_expired_d = 1'b0;
    end
    charge_en_d = charge_req && !wd_expired_d;
  end

  // Watchdog registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tick_cnt_q   <= '0;
      wd_cnt_q     <= '0;
      wd_sel_q     <= hcwd_pkg::WD_SEL_RST;
      wd_expired_q <= 1'b0;
      charge_en_q  <= 1'b0;
    end else begin
      tick_cnt_q   <= tick_cnt_d;
      wd_cnt_q     <= wd_cnt_d;
      wd_sel_q     <= wd_sel_d;
      wd_expired_q <= wd_expired_d;
      charge_en_q  <= charge_en_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  int unsigned low_run;
  // Length of the current filtered clock-low run, for checks only
  always_ff @(posedge sys_clk) begin
    if (!rst_b || scl_lvl) begin
      low_run <= 0;
    end else begin
      low_run <= low_run + 1;
    end
  end

  logic        chk_sync1_q;
  logic        chk_sync2_q;
  int unsigned wdr_hi_run;
  // Own two-stage copy of the watchdog reset pin, so the check never reads the raw pin
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      chk_sync1_q <= 1'b0;
      chk_sync2_q <= 1'b0;
    end else begin
      chk_sync1_q <= wd_rst_pin;
      chk_sync2_q <= chk_sync1_q;
    end
  end

  // Consecutive synchronised high cycles of the watchdog reset, for checks only
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !chk_sync2_q) begin
      wdr_hi_run <= 0;
    end else begin
      wdr_hi_run <= wdr_hi_run + 1;
    end
  end

  bus_reset_late_a: assert property (bus_reset_q |-> low_run >= BUS_TMO_CYC)
    else $error("bus reset before clock-low timeout");
  bus_reset_due_a: assert property (low_run <= hcwd_pkg::BUS_TMO_MAX_CYC || tmo_done_q)
    else $error("bus not reset within maximum timeout");
  bus_reset_once_a: assert property (bus_reset_q |=> !bus_reset_q)
    else $error("bus reset longer than one cycle");
  stretch_cap_a: assert property (str_cnt_q <= CW'(STRETCH_CYC + 2))
    else $error("own stretch exceeded budget");
  deglitch_hold_a: assert property (wdr_rise |-> wdr_hi_run >= DEGL_CYC)
    else $error("watchdog reset taken without holding");
  sel_default_a: assert property ($rose(rst_b) |-> wd_sel_q == hcwd_pkg::WD_SEL_RST)
    else $error("period select not default after reset");
  sel_write_a: assert property (opt_wr |=> wd_sel_q == $past(opt_wd_sel))
    else $error("written period select not applied");
  expire_stop_a: assert property (wd_expired_q |-> !charge_en_q)
    else $error("charging while watchdog expired");
  expire_time_a: assert property (wd_on && !wd_expired_q && !service
                                  && wd_cnt_q >= sel_period(wd_sel_q) |=> wd_expired_q)
    else $error("watchdog failed to expire at period");
  service_clear_a: assert property (host_wr && !(wd_on && wd_cnt_q >= sel_period(wd_sel_q))
                                    |=> wd_cnt_q == '0 && !wd_expired_q)
    else $error("host write did not restart watchdog");

endmodule : hcwd_top

// [bench/hcwd_host.sv]
// Host side model: bus master clock, host writes and option updates
module hcwd_host (
  input  wire logic sys_clk,    // System clock
  output logic      scl_pin,    // Bus clock, pulled up while idle
  output logic      host_wr,    // Pulse: host write accepted
  output logic      opt_wr,     // Pulse: option register written
  output logic [1:0] opt_wd_sel // Period select being written
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus sits at the pull-up level, no write pending
  initial begin
    scl_pin = 1'b1;
    host_wr = 1'b0;
    opt_wr = 1'b0;
    opt_wd_sel = 2'h0;
  end
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
    end
  endtask : tick
  // Frame of n clocks at 800 ns; lows stay far below any stretch limit
  task automatic frame(input int n);
    repeat (n) begin
      scl_pin = 1'b0;
      tick(4);
      scl_pin = 1'b1;
      tick(4);
    end
    host_wr = 1'b1;
    tick(1);
    host_wr = 1'b0;
  endtask : frame
  // Clock held low for n cycles, only when a scenario asks for it
  task automatic hold_low(input int n);
    scl_pin = 1'b0;
    tick(n);
    scl_pin = 1'b1;
  endtask : hold_low
  // Option write carrying a new period select
  task automatic write_opt(input logic [1:0] sel);
    opt_wd_sel = sel;
    opt_wr = 1'b1;
    tick(1);
    opt_wr = 1'b0;
  endtask : write_opt
endmodule : hcwd_host

// [bench/hcwd_top_test.sv]
// Self-checking bench for the host communication watchdog
module hcwd_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Shortened counts so the run stays brief
  // ---------------------------------------------------------------
  localparam int TK = 10;
  localparam int BT = 50;
  localparam int ST = 40;
  localparam int DG = 20;
  localparam int PER [4] = '{0, hcwd_pkg::WD_PER_A_MS, 5, 8};
  // Select 01 keeps its full period, so the expiry wait must cover it
  localparam int WAIT_MAX = 60000;
  logic sys_clk, rst_b, wd_rst_pin, xfer_active, dev_scl_hold, charge_req;
  logic scl_pin, host_wr, opt_wr, bus_reset_q, scl_release_q, wd_expired_q, charge_en_q;
  logic [1:0] opt_wd_sel, wd_sel_q;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int rst_cnt = 0;
  int rst_at = 0;
  hcwd_top #(.TICK_CYC(TK), .BUS_TMO_CYC(BT), .STRETCH_CYC(ST), .DEGL_CYC(DG),
    .PER_B_MS(5), .PER_C_MS(8)) i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .scl_pin(scl_pin), .wd_rst_pin(wd_rst_pin),
    .host_wr(host_wr), .opt_wr(opt_wr), .opt_wd_sel(opt_wd_sel), .xfer_active(xfer_active),
    .dev_scl_hold(dev_scl_hold), .charge_req(charge_req), .bus_reset_q(bus_reset_q),
    .scl_release_q(scl_release_q), .wd_sel_q(wd_sel_q), .wd_expired_q(wd_expired_q),
    .charge_en_q(charge_en_q));
  hcwd_host i_host (.sys_clk(sys_clk), .scl_pin(scl_pin), .host_wr(host_wr), .opt_wr(opt_wr),
    .opt_wd_sel(opt_wd_sel));
  // Clock and cycle count; bus reset pulses are logged as they come
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (bus_reset_q === 1'b1) begin
      rst_cnt <= rst_cnt + 1;
      rst_at <= cyc;
    end
  end
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
    end
  endtask : tick
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic check_val(input logic [1:0] got, input logic [1:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : check_val
  task automatic check_range(input int got, input int lo, input int hi, input string what);
    total_checks++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("Error at %0t: %s took %0d, expected %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : check_range
  // Bounded wait for expiry; a hang ends the run
  task automatic wait_expiry(output int k);
    k = 0;
    while (wd_expired_q !== 1'b1 && k < WAIT_MAX) begin
      tick(1);
      k++;
    end
    if (wd_expired_q !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: no expiry", $time);
      conclude();
    end
  endtask : wait_expiry
  task automatic t_bus();
    int f;
    int base;
    base = rst_cnt;
    i_host.frame(3);
    i_host.hold_low(30);
    tick(10);
    check_val(2'(rst_cnt - base), 2'h0, "short lows");
    f = cyc;
    i_host.hold_low(80);
    tick(5);
    check_val(2'(rst_cnt - base), 2'h1, "reset pulses");
    check_range(rst_at - f, BT + 2, BT + 7, "bus reset");
    $display("test bus timeout done");
  endtask : t_bus
  task automatic t_stretch();
    int k;
    xfer_active = 1'b1;
    dev_scl_hold = 1'b1;
    k = 0;
    while (scl_release_q !== 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    check_range(k, ST + 1, ST + 4, "stretch release");
    dev_scl_hold = 1'b0;
    xfer_active = 1'b0;
    tick(3);
    check_val({1'b0, scl_release_q}, 2'h0, "release cleared");
    $display("test stretch budget done");
  endtask : t_stretch
  task automatic t_period();
    int k;
    for (int s = 1; s < 4; s++) begin
      i_host.write_opt(2'(s));
      check_val(wd_sel_q, 2'(s), "select");
      check_val({1'b0, wd_expired_q}, 2'h0, "expiry cleared");
      wait_expiry(k);
      check_range(k, (PER[s] - 1) * TK, PER[s] * TK + 2, "period");
      check_val({1'b0, charge_en_q}, 2'h0, "charge stop");
    end
    i_host.write_opt(2'h0);
    tick(150);
    check_val({wd_expired_q, charge_en_q}, 2'h1, "disabled");
    $display("test periods done");
  endtask : t_period
  task automatic t_service();
    int k;
    i_host.write_opt(2'h2);
    repeat (4) i_host.frame(2);
    check_val({wd_expired_q, charge_en_q}, 2'h1, "serviced");
    wait_expiry(k);
    i_host.frame(1);
    tick(1);
    check_val({wd_expired_q, charge_en_q}, 2'h1, "cleared by write");
    $display("test service done");
  endtask : t_service
  task automatic t_deglitch();
    int k;
    wait_expiry(k);
    wd_rst_pin = 1'b1;
    tick(DG - 5);
    wd_rst_pin = 1'b0;
    tick(6);
    check_val({1'b0, wd_expired_q}, 2'h1, "short pin pulse");
    wd_rst_pin = 1'b1;
    tick(DG + 8);
    wd_rst_pin = 1'b0;
    tick(2);
    check_val({1'b0, wd_expired_q}, 2'h0, "long pin pulse");
    $display("test deglitch done");
  endtask : t_deglitch
  // Reset in mid-run restores the default select; charge follows its request
  task automatic t_restart();
    rst_b = 1'b0;
    tick(5);
    rst_b = 1'b1;
    tick(1);
    check_val(wd_sel_q, 2'h3, "select after reset");
    check_val({wd_expired_q, bus_reset_q}, 2'h0, "state after reset");
    charge_req = 1'b0;
    tick(1);
    check_val({1'b0, charge_en_q}, 2'h0, "charge request off");
    charge_req = 1'b1;
    tick(1);
    check_val({1'b0, charge_en_q}, 2'h1, "charge request on");
    $display("test restart done");
  endtask : t_restart
  // Main sequence: reset, defaults, then each scenario
  initial begin
    rst_b = 1'b0;
    wd_rst_pin = 1'b0;
    xfer_active = 1'b0;
    dev_scl_hold = 1'b0;
    charge_req = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    tick(1);
    check_val(wd_sel_q, 2'h3, "default select");
    check_val({bus_reset_q, scl_release_q}, 2'h0, "idle outputs");
    charge_req = 1'b1;
    tick(3);
    check_val({wd_expired_q, charge_en_q}, 2'h1, "charge on");
    $display("test reset done");
    t_bus();
    t_stretch();
    t_period();
    t_service();
    t_deglitch();
    t_restart();
    conclude();
  end
endmodule : hcwd_top_test
